//--- mem_pins_pkg.sv
// Constants and carrier types for the shared SDRAM/flash pin multiplexer.
// Assumes a single 250 MHz core clock and a synchronous active-high reset.
package mem_pins_pkg;

  localparam int CLK_PERIOD_NS = 4;
  // Strap level meaning parallel flash
  localparam logic STRAP_PARALLEL = 1'b1;
  // Reset cycles before the strap level is captured (pin settles through sync)
  localparam int STRAP_WAIT_CYCLES = 3;
  localparam logic [1:0] STRAP_CNT_W2 = 2'h3;
  localparam int SDRAM_ADDR_W = 25;   // 32 MB
  localparam int FLASH_ADDR_W = 24;   // 16 MB
  localparam int SDRAM_CLK_DIV = 2;   // SDRAM clock = core / (2*div)
  localparam logic [1:0] CLK_DIV_LAST = 2'h1;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_SDRAM = 2'b01,
    CYC_FLASH = 2'b11
  } cycle_e;

  // Request from the SDRAM controller
  typedef struct packed {
    logic active;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [1:0] dqm_n;
    logic [15:0] wdata;
    logic drive;
  } sdram_req_s;

  // Request from the flash controller
  typedef struct packed {
    logic active;
    logic chip;
    logic we_n;
    logic [1:0] oe_n;
    logic [FLASH_ADDR_W:0] addr;  // bit 0 is the byte address lsb
    logic [7:0] wdata;
    logic drive;
    logic sck;
    logic sdo;
  } flash_req_s;

  // Pin bundle toward the board
  typedef struct packed {
    logic [7:0] dq_low;
    logic [7:0] dq_low_oe;
    logic [6:0] dq_high;
    logic dq15;
    logic dq_high_oe;
    logic [7:0] addr_mid;
    logic addr12;
    logic addr12_oe;
    logic upper_byte_enable;
    logic lower_byte_enable;
    logic row_strobe_or_addr14;
    logic col_strobe_or_addr13;
    logic bank_sel0_or_addr15;
    logic bank_sel1_or_addr16;
    logic sdram_cs_n;
    logic flash0_select;
    logic flash1_select;
    logic we_n;
  } pins_s;

endpackage

//--- shared_sdram_flash_bus_pins.sv
// Shared pin multiplexer for the SDRAM and boot flash bus.
// Assumes upstream SDRAM and flash controllers share via this block's grant.
//
// Contract
// - The flash-type strap is sampled during reset: high means parallel, low serial.
// - In serial mode data bit 2 drives flash clock, bit 1 data out, bit 0 data in.
// - The low data byte is shared by SDRAM and flash cycles.
// - The upper data byte is SDRAM data 15..8 or flash address, bit 15 the address lsb.
// - Address pins 4..11 carry address to both SDRAM and parallel flash.
// - After sampling, the strap pin is driven as address bit 12 for both memories.
// - The two byte enables act as SDRAM data masks or flash output enables.
// - Row and column strobes carry flash address 14 and 13 in parallel flash cycles.
// - Bank selects pick the SDRAM bank or carry flash address 15 and 16.
// - A dedicated clock output times SDRAM cycles.
// - Two separate flash chip selects serve two flash devices.
// - The SDRAM chip select is active low.
// - One active-low write enable serves SDRAM and parallel flash.
// - Addressing reaches 16 MB of flash and 32 MB of SDRAM.
module shared_sdram_flash_bus_pins
  import mem_pins_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  input wire sdram_req_s sdram_req,
  input wire flash_req_s flash_req,
  output logic sdram_grant,
  output logic flash_grant,
  output logic parallel_flash,
  output logic [15:0] sdram_rdata,
  output logic [7:0] flash_rdata,
  output logic serial_din,
  // Board pins
  input wire logic [15:0] dq_in,
  input wire logic addr12_in,
  output pins_s pins,
  output logic sdram_clk
);

  cycle_e cyc_reg;
  cycle_e cyc_next;
  logic strap_s1_reg;
  logic strap_s2_reg;
  logic parallel_reg;
  logic [15:0] dq_s1_reg;
  logic [15:0] dq_s2_reg;
  logic [1:0] div_reg;
  logic sdram_clk_reg;
  pins_s pins_reg;
  pins_s pins_next;

  always_ff @(posedge clk) begin
    strap_s1_reg <= addr12_in;
    strap_s2_reg <= strap_s1_reg;
  end

  // capture strap while reset held
  // Last reset cycle wins; reset must outlast the two sync stages
  always_ff @(posedge clk) begin
    if (rst) begin
      parallel_reg <= (strap_s2_reg == STRAP_PARALLEL);
    end
  end

  // Data inputs come from the board
  always_ff @(posedge clk) begin
    dq_s1_reg <= dq_in;
    dq_s2_reg <= dq_s1_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 2'h0;
      sdram_clk_reg <= 1'b0;
    end else if (div_reg == CLK_DIV_LAST) begin
      div_reg <= 2'h0;
      sdram_clk_reg <= ~sdram_clk_reg;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end

  // arbitration, an owner keeps the bus until it drops active
  always_comb begin
    cyc_next = cyc_reg;
    unique case (cyc_reg)
      CYC_IDLE: begin
        if (sdram_req.active) begin
          cyc_next = CYC_SDRAM;
        end else if (flash_req.active) begin
          cyc_next = CYC_FLASH;
        end
      end
      CYC_SDRAM: begin
        if (!sdram_req.active) begin
          cyc_next = CYC_IDLE;
        end
      end
      CYC_FLASH: begin
        if (!flash_req.active) begin
          cyc_next = CYC_IDLE;
        end
      end
      default: cyc_next = CYC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cyc_reg <= CYC_IDLE;
    end else begin
      cyc_reg <= cyc_next;
    end
  end

  // Pin values for the cycle about to run
  always_comb begin
    pins_next = '0;
    pins_next.sdram_cs_n = 1'b1;
    pins_next.flash0_select = 1'b1;
    pins_next.flash1_select = 1'b1;
    pins_next.we_n = 1'b1;
    pins_next.upper_byte_enable = 1'b1;
    pins_next.lower_byte_enable = 1'b1;
    pins_next.row_strobe_or_addr14 = 1'b1;
    pins_next.col_strobe_or_addr13 = 1'b1;
    // strap pin becomes address 12 once sampled
    pins_next.addr12_oe = 1'b1;
    unique case (cyc_next)
      CYC_SDRAM: begin
        pins_next.sdram_cs_n = sdram_req.cs_n;
        pins_next.row_strobe_or_addr14 = sdram_req.ras_n;
        pins_next.col_strobe_or_addr13 = sdram_req.cas_n;
        pins_next.we_n = sdram_req.we_n;
        pins_next.bank_sel0_or_addr15 = sdram_req.bank[0];
        pins_next.bank_sel1_or_addr16 = sdram_req.bank[1];
        pins_next.addr_mid = sdram_req.addr[11:4];
        pins_next.addr12 = sdram_req.addr[12];
        pins_next.upper_byte_enable = sdram_req.dqm_n[1];
        pins_next.lower_byte_enable = sdram_req.dqm_n[0];
        pins_next.dq_low = sdram_req.wdata[7:0];
        pins_next.dq_low_oe = {8{sdram_req.drive}};
        pins_next.dq_high = sdram_req.wdata[14:8];
        pins_next.dq15 = sdram_req.wdata[15];
        pins_next.dq_high_oe = sdram_req.drive;
      end
      CYC_FLASH: begin
        pins_next.flash0_select = flash_req.chip;
        pins_next.flash1_select = ~flash_req.chip;
        if (parallel_reg) begin
          pins_next.we_n = flash_req.we_n;
          pins_next.upper_byte_enable = flash_req.oe_n[1];
          pins_next.lower_byte_enable = flash_req.oe_n[0];
          // lsb plus high address on upper data pins
          pins_next.dq15 = flash_req.addr[0];
          pins_next.dq_high = flash_req.addr[24:18];
          pins_next.dq_high_oe = 1'b1;
          pins_next.addr_mid = flash_req.addr[12:5];
          pins_next.addr12 = flash_req.addr[13];
          // strobes as address 14 and 13
          pins_next.col_strobe_or_addr13 = flash_req.addr[14];
          pins_next.row_strobe_or_addr14 = flash_req.addr[15];
          // banks as address 15 and 16
          pins_next.bank_sel0_or_addr15 = flash_req.addr[16];
          pins_next.bank_sel1_or_addr16 = flash_req.addr[17];
          pins_next.dq_low = flash_req.wdata;
          pins_next.dq_low_oe = {8{flash_req.drive}};
        end else begin
          // serial clock, data out, data in
          pins_next.dq_low[2] = flash_req.sck;
          pins_next.dq_low[1] = flash_req.sdo;
          pins_next.dq_low_oe = 8'h06;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pins_reg <= '0;
      pins_reg.sdram_cs_n <= 1'b1;
      pins_reg.flash0_select <= 1'b1;
      pins_reg.flash1_select <= 1'b1;
      pins_reg.we_n <= 1'b1;
      pins_reg.upper_byte_enable <= 1'b1;
      pins_reg.lower_byte_enable <= 1'b1;
      pins_reg.row_strobe_or_addr14 <= 1'b1;
      pins_reg.col_strobe_or_addr13 <= 1'b1;
    end else begin
      pins_reg <= pins_next;
    end
  end

  // Read data captured from synchronised pins
  always_ff @(posedge clk) begin
    if (rst) begin
      sdram_rdata <= 16'h0000;
      flash_rdata <= 8'h00;
      serial_din <= 1'b0;
    end else begin
      sdram_rdata <= dq_s2_reg;
      flash_rdata <= dq_s2_reg[7:0];
      // serial data in on bit 0
      serial_din <= dq_s2_reg[0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sdram_grant <= 1'b0;
      flash_grant <= 1'b0;
    end else begin
      sdram_grant <= (cyc_next == CYC_SDRAM);
      flash_grant <= (cyc_next == CYC_FLASH);
    end
  end

  // Follows the strap during reset so it stands still after release
  always_ff @(posedge clk) begin
    parallel_flash <= parallel_reg;
  end

  assign pins = pins_reg;
  assign sdram_clk = sdram_clk_reg;

endmodule

//--- mem_pins_asserts.sv
// Checker for the shared SDRAM/flash pin multiplexer.
// Bound to the top module; sees its ports only.
module mem_pins_asserts
  import mem_pins_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire sdram_req_s sdram_req,
  input wire flash_req_s flash_req,
  input wire logic sdram_grant,
  input wire logic flash_grant,
  input wire logic parallel_flash,
  input wire pins_s pins,
  input wire logic sdram_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_one_owner;
    !(sdram_grant && flash_grant) && !(!pins.sdram_cs_n && !(pins.flash0_select && pins.flash1_select));
  endproperty
  property p_sdram_ctl;
    sdram_grant |-> pins.sdram_cs_n == $past(sdram_req.cs_n) && pins.we_n == $past(sdram_req.we_n);
  endproperty
  property p_flash_hi;
    flash_grant && parallel_flash |-> {pins.bank_sel1_or_addr16, pins.bank_sel0_or_addr15,
      pins.row_strobe_or_addr14,
      pins.col_strobe_or_addr13, pins.addr12} == $past(flash_req.addr[17:13]);
  endproperty
  property p_mid;
    flash_grant && parallel_flash |-> pins.addr_mid == $past(flash_req.addr[12:5]);
  endproperty
  property p_par_addr;
    flash_grant && parallel_flash |-> {pins.dq_high, pins.dq15} == {$past(flash_req.addr[24:18]),
      $past(flash_req.addr[0])};
  endproperty
  property p_serial;
    flash_grant && !parallel_flash |-> pins.dq_low_oe == 8'h06 &&
      pins.dq_low[2:1] == {$past(flash_req.sck), $past(flash_req.sdo)};
  endproperty
  property p_chip;
    flash_grant |-> pins.flash0_select == $past(flash_req.chip) && pins.flash1_select != $past(flash_req.chip);
  endproperty
  property p_clk;
    $rose(sdram_clk) |=> sdram_clk ##1 !sdram_clk;
  endproperty
  property p_strap;
    !$past(rst) |-> $stable(parallel_flash) && pins.addr12_oe;
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("two owners on the pins");
  a_sdram_ctl: assert property (p_sdram_ctl) else $error("sdram select or write enable");
  a_flash_hi: assert property (p_flash_hi) else $error("flash upper address pins");
  a_mid: assert property (p_mid) else $error("flash mid address pins");
  a_par_addr: assert property (p_par_addr) else $error("flash address on data pins");
  a_serial: assert property (p_serial) else $error("serial flash pins");
  a_chip: assert property (p_chip) else $error("flash chip select");
  a_clk: assert property (p_clk) else $error("sdram clock rate");
  a_strap: assert property (p_strap) else $error("strap result or pin drive");
  c_sdram: cover property (sdram_grant);
  c_par: cover property (flash_grant && parallel_flash);
  c_ser: cover property (flash_grant && !parallel_flash);
endmodule
bind shared_sdram_flash_bus_pins mem_pins_asserts i_mem_pins_asserts (.clk, .rst, .sdram_req,
  .flash_req, .sdram_grant, .flash_grant, .parallel_flash, .pins, .sdram_clk);

//--- mem_chips_model.sv
// External SDRAM and flash chips seen at the shared pins.
// Strap resistor level comes from the bench.
module mem_chips_model
  import mem_pins_pkg::*;
(
  input wire logic clk,
  input wire logic strap_level,
  input wire pins_s pins,
  output logic [15:0] dq_in,
  output logic [7:0] low_val,
  output logic addr12_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines wander so a stale value never passes
  logic [15:0] float_reg = 16'hA5C3;
  always_ff @(posedge clk) float_reg <= ~float_reg;
  assign addr12_in = pins.addr12_oe ? pins.addr12 : strap_level;
  // flash read echoes address; serial flash loops data back
  always_comb begin
    low_val = float_reg[7:0];
    if (!(pins.flash0_select && pins.flash1_select) && !pins.lower_byte_enable) low_val = pins.addr_mid;
    low_val = (low_val & ~pins.dq_low_oe) | (pins.dq_low & pins.dq_low_oe);
    if (pins.dq_low_oe == 8'h06) low_val[0] = pins.dq_low[1];
  end
  assign dq_in = {pins.dq_high_oe ? {pins.dq15, pins.dq_high} : float_reg[15:8], low_val};
endmodule

//--- test_shared_sdram_flash_bus_pins.sv
// Self-checking bench for the shared SDRAM/flash pin multiplexer.
// The chip model closes the board side of the pins.
module test_shared_sdram_flash_bus_pins
  import mem_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap_level = 1'b1;
  sdram_req_s sdram_req = '0;
  flash_req_s flash_req = '0;
  logic sdram_grant, flash_grant, parallel_flash, serial_din, sdram_clk, addr12_in;
  logic [15:0] sdram_rdata, dq_in;
  logic [7:0] flash_rdata;
  pins_s pins;
  int mismatches = 0;
  int compares = 0;
  initial forever #2 clk = ~clk;
  shared_sdram_flash_bus_pins i_shared_sdram_flash_bus_pins (.clk, .rst, .sdram_req, .flash_req,
    .sdram_grant, .flash_grant, .parallel_flash, .sdram_rdata, .flash_rdata, .serial_din, .dq_in,
    .addr12_in, .pins, .sdram_clk);
  mem_chips_model i_mem_chips_model (.clk, .strap_level, .pins, .dq_in, .low_val(), .addr12_in);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_for(input logic fl);
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      #1;
      if ((fl ? flash_grant : sdram_grant) === 1'b1) return;
    end
    mismatches++;
    final_report();
  endtask
  task automatic t_reset(input logic lvl);
    @(posedge clk);
    rst <= 1'b1;
    strap_level <= lvl;
    sdram_req <= '0;
    flash_req <= '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({parallel_flash, pins.addr12_oe}, {lvl, 1'b1});
  endtask
  task automatic t_flash(input logic chip);
    @(posedge clk);
    flash_req <= '{1'b1, chip, 1'b1, 2'h2, 25'h1B3C5A7, 8'h00, 1'b0, 1'b0, 1'b0};
    wait_for(1'b1);
    chk({pins.dq_high, pins.dq15}, {7'h6C, 1'b1});
    chk(pins.addr_mid, 8'h2D);
    chk({pins.bank_sel1_or_addr16, pins.bank_sel0_or_addr15, pins.row_strobe_or_addr14,
      pins.col_strobe_or_addr13, pins.addr12}, 5'h1E);
    chk({pins.flash1_select, pins.flash0_select}, chip ? 2'h1 : 2'h2);
    chk({pins.sdram_cs_n, pins.upper_byte_enable, pins.lower_byte_enable}, 3'h6);
    repeat (5) @(posedge clk);
    #1;
    chk(flash_rdata, 8'h2D);
    @(posedge clk);
    flash_req.active <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_sdram;
    int n;
    logic prev;
    @(posedge clk);
    sdram_req <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2, 13'h1A5C, 2'h1, 16'hC35A, 1'b1};
    flash_req.active <= 1'b1;
    wait_for(1'b0);
    chk({pins.sdram_cs_n, pins.we_n, pins.bank_sel1_or_addr16, pins.bank_sel0_or_addr15}, 4'h2);
    chk({pins.addr12, pins.addr_mid}, 9'h1A5);
    chk({pins.dq15, pins.dq_high, pins.dq_low}, 16'hC35A);
    chk({pins.upper_byte_enable, pins.lower_byte_enable, pins.flash1_select, pins.flash0_select,
      flash_grant}, 5'h0E);
    n = 0;
    prev = sdram_clk;
    repeat (16) begin
      @(posedge clk);
      #1;
      n += int'(sdram_clk !== prev);
      prev = sdram_clk;
    end
    chk(n, 8);
    @(posedge clk);
    sdram_req.active <= 1'b0;
    wait_for(1'b1);
    chk({pins.flash1_select, pins.sdram_cs_n, sdram_grant}, 3'h2);
  endtask
  task automatic t_serial;
    @(posedge clk);
    flash_req <= '{1'b1, 1'b0, 1'b1, 2'h3, 25'h0, 8'h00, 1'b0, 1'b0, 1'b0};
    wait_for(1'b1);
    // Flash clock at 80 ns period, sampled by the core clock
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      flash_req.sck <= i[0];
      flash_req.sdo <= i[1];
      repeat (9) @(posedge clk);
      #1;
      chk({pins.dq_low_oe, pins.dq_low[2:1], serial_din}, {8'h06, i[0], i[1], i[1]});
    end
  endtask
  initial begin
    t_reset(1'b1);
    t_flash(1'b0);
    t_flash(1'b1);
    t_sdram();
    t_reset(1'b0);
    t_serial();
    final_report();
  end
endmodule
